//--- verilog/uabt_pkg.sv
`default_nettype none
package uabt_pkg;
    // Register byte addresses on the bus
    localparam logic [7:0] ADR_STATUS = 8'h00;
    localparam logic [7:0] ADR_CTRL_ONE = 8'h04;
    localparam logic [7:0] ADR_CTRL_TWO = 8'h08;
    localparam logic [7:0] ADR_DATA = 8'h0c;
    localparam logic [7:0] ADR_BAUD = 8'h10;

    // serial_control_one fields
    localparam int C1_PORT_EN = 7;
    localparam int C1_NINE = 6;
    localparam int C1_PAR_EN = 5;
    localparam int C1_PAR_ODD = 4;
    localparam int C1_TWO_STOP = 3;
    localparam int C1_NINTH_BIT = 0;
    localparam logic [7:0] C1_MASK = 8'hf9;
    localparam logic [7:0] C1_RST = 8'h00;

    // serial_control_two fields
    localparam int C2_TX_EN = 7;
    localparam int C2_RX_EN = 6;
    localparam int C2_SPEED = 5;
    localparam int C2_BREAK = 2;
    localparam int C2_IDLE_IE = 1;
    localparam int C2_EMPTY_IE = 0;
    localparam logic [7:0] C2_MASK = 8'he7;
    localparam logic [7:0] C2_RST = 8'h00;
    localparam logic [7:0] C2_DISABLE_CLR = 8'hc4;

    // serial_status_reg fields
    localparam int ST_RX_AVAIL = 0;
    localparam int ST_OVERRUN = 1;
    localparam int ST_FRAMING = 2;
    localparam int ST_PARITY = 3;
    localparam int ST_NOISE = 4;
    localparam int ST_RX_IDLE = 5;
    localparam int ST_TX_IDLE = 6;
    localparam int ST_TX_EMPTY = 7;

    // Baud timer prescale terminal counts (64 and 16 clocks)
    localparam logic [5:0] PRESCALE_LOW = 6'h3f;
    localparam logic [5:0] PRESCALE_HIGH = 6'h0f;
    localparam logic [7:0] BAUD_RST = 8'h00;

    // Frame shape
    localparam int FRAME_W = 12;
    localparam logic [3:0] LEN_BASE = 4'h1;
    localparam logic [3:0] DATA_EIGHT = 4'h8;
    localparam logic [3:0] DATA_NINE = 4'h9;
    localparam logic [3:0] STOP_ONE = 4'h1;
    localparam logic [3:0] STOP_TWO = 4'h2;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_ARM = 2'b01,
        TX_SEND = 2'b11,
        TX_DONE = 2'b10
    } uabt_tx_state_e;
endpackage
`default_nettype wire

//--- verilog/uabt_baud.sv
`default_nettype none
module uabt_baud (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_run,
    input wire logic i_speed,
    input wire logic [7:0] i_divisor,
    output logic o_tick
);
    logic [5:0] pre_q;
    logic [7:0] div_q;
    logic [5:0] pre_last;

    // speed select picks 64 or 16 clocks
    assign pre_last = i_speed ? uabt_pkg::PRESCALE_HIGH : uabt_pkg::PRESCALE_LOW;

    // counters held cleared while port is off
    always_ff @(posedge i_clk) begin
        if (i_rst || !i_run) begin
            pre_q <= 6'h00;
            div_q <= 8'h00;
            o_tick <= 1'b0;
        end else begin
            o_tick <= 1'b0;
            if (pre_q >= pre_last) begin // >= survives a speed change
                pre_q <= 6'h00;
                if (div_q >= i_divisor) begin
                    div_q <= 8'h00;
                    o_tick <= 1'b1;
                end else begin
                    div_q <= div_q + 8'h01;
                end
            end else begin
                pre_q <= pre_q + 6'h01;
            end
        end
    end

    // Checking aid: cycles between ticks under steady settings
    logic [15:0] gap_q;
    logic seen_q;
    logic dirty_q;
    logic [8:0] last_cfg_q;
    logic [15:0] period;

    assign period = ({10'h000, pre_last} + 16'h0001) * ({8'h00, i_divisor} + 16'h0001);

    always_ff @(posedge i_clk) begin
        last_cfg_q <= {i_speed, i_divisor};
        if (i_rst || !i_run) begin
            gap_q <= 16'h0000;
            seen_q <= 1'b0;
            dirty_q <= 1'b0;
        end else if (o_tick) begin
            gap_q <= 16'h0000;
            seen_q <= 1'b1;
            dirty_q <= 1'b0;
        end else begin
            gap_q <= gap_q + 16'h0001;
            if (last_cfg_q != {i_speed, i_divisor}) begin
                dirty_q <= 1'b1;
            end
        end
    end

    AST_TICK_PERIOD: assert property (@(posedge i_clk) disable iff (i_rst)
        (o_tick && seen_q && !dirty_q && last_cfg_q == {i_speed, i_divisor})
        |-> (gap_q + 16'h0001 == period))
        else $error("Baud tick spacing wrong");
    AST_TICK_PULSE: assert property (@(posedge i_clk) disable iff (i_rst)
        o_tick |=> !o_tick)
        else $error("Baud tick longer than one cycle");
    COV_TICK: cover property (@(posedge i_clk) disable iff (i_rst)
        o_tick && seen_q);
endmodule
`default_nettype wire

//--- verilog/uabt_top.sv
`default_nettype none
module uabt_top (
    input wire logic I_MCLK,
    input wire logic I_RST,
    input wire logic I_WB_CYC,
    input wire logic I_WB_STB,
    input wire logic I_WB_WE,
    input wire logic [7:0] I_WB_ADR,
    input wire logic [31:0] I_WB_DAT,
    input wire logic [3:0] I_WB_SEL,
    output logic [31:0] O_WB_DAT,
    output logic O_WB_ACK,
    output logic O_TX,
    output logic O_TX_OE,
    output logic O_RX_EN,
    output logic O_TX_IRQ
);
    logic [7:0] serial_control_one_q;
    logic [7:0] serial_control_two_q;
    logic [7:0] baud_divisor_q;
    logic [7:0] serial_data_buffer_q;
    logic transmit_empty_flag_q;
    logic transmit_idle_flag_q;
    logic status_armed_q;
    logic [uabt_pkg::FRAME_W-1:0] transmit_shift_reg_q;
    logic [3:0] frame_len_q;
    logic [3:0] bit_cnt_q;
    uabt_pkg::uabt_tx_state_e state_q;

    logic port_enable;
    logic transmit_enable;
    logic wb_req;
    logic wb_wr;
    logic wb_rd;
    logic data_wr_ok;
    logic load;
    logic tick;
    logic [7:0] status_byte;
    logic [7:0] rd_byte;
    logic [8:0] word;
    logic [uabt_pkg::FRAME_W-1:0] frame_d;
    logic [3:0] len_d;
    logic par8;
    logic par9;

    assign port_enable = serial_control_one_q[uabt_pkg::C1_PORT_EN];
    assign transmit_enable = port_enable && serial_control_two_q[uabt_pkg::C2_TX_EN];

    // Bus request decode; one access per ack, ack drops next cycle
    assign wb_req = I_WB_CYC && I_WB_STB && !O_WB_ACK;
    assign wb_wr = wb_req && I_WB_WE && I_WB_SEL[0];
    assign wb_rd = wb_req && !I_WB_WE;

    // one rate and one format serve the transmit direction only
    uabt_baud u_baud (
        .i_clk(I_MCLK),
        .i_rst(I_RST),
        .i_run(port_enable),
        .i_speed(serial_control_two_q[uabt_pkg::C2_SPEED]),
        .i_divisor(baud_divisor_q),
        .o_tick(tick)
    );

    // Bus acknowledge, registered one cycle after request
    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            O_WB_ACK <= 1'b0;
        end else begin
            O_WB_ACK <= wb_req;
        end
    end

    // receive side flags read in their disabled state
    always_comb begin
        status_byte = 8'h00;
        status_byte[uabt_pkg::ST_RX_IDLE] = 1'b1;
        status_byte[uabt_pkg::ST_TX_IDLE] = transmit_idle_flag_q;
        status_byte[uabt_pkg::ST_TX_EMPTY] = transmit_empty_flag_q;
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        unique case (I_WB_ADR)
            uabt_pkg::ADR_STATUS: rd_byte = status_byte;
            uabt_pkg::ADR_CTRL_ONE: rd_byte = serial_control_one_q;
            uabt_pkg::ADR_CTRL_TWO: rd_byte = serial_control_two_q;
            uabt_pkg::ADR_DATA: rd_byte = serial_data_buffer_q;
            uabt_pkg::ADR_BAUD: rd_byte = baud_divisor_q;
            default: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            O_WB_DAT <= 32'h00000000;
        end else if (wb_rd) begin
            O_WB_DAT <= {24'h000000, rd_byte};
        end
    end

    // power-on format; settings kept across disable
    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            serial_control_one_q <= uabt_pkg::C1_RST;
        end else if (wb_wr && I_WB_ADR == uabt_pkg::ADR_CTRL_ONE) begin
            serial_control_one_q <= I_WB_DAT[7:0] & uabt_pkg::C1_MASK;
        end
    end

    // enables and break forced clear while port is off
    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            serial_control_two_q <= uabt_pkg::C2_RST;
        end else if (!port_enable) begin
            serial_control_two_q <= serial_control_two_q & ~uabt_pkg::C2_DISABLE_CLR;
        end else if (wb_wr && I_WB_ADR == uabt_pkg::ADR_CTRL_TWO) begin
            serial_control_two_q <= I_WB_DAT[7:0] & uabt_pkg::C2_MASK;
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            baud_divisor_q <= uabt_pkg::BAUD_RST;
        end else if (wb_wr && I_WB_ADR == uabt_pkg::ADR_BAUD) begin
            baud_divisor_q <= I_WB_DAT[7:0];
        end
    end

    // status read arms the clearing write
    always_ff @(posedge I_MCLK) begin
        if (I_RST || !port_enable) begin
            status_armed_q <= 1'b0;
        end else if (wb_rd && I_WB_ADR == uabt_pkg::ADR_STATUS) begin
            status_armed_q <= 1'b1;
        end else if (wb_wr && I_WB_ADR == uabt_pkg::ADR_DATA) begin
            status_armed_q <= 1'b0;
        end
    end

    // write dropped unless buffer empty and armed
    assign data_wr_ok = wb_wr && I_WB_ADR == uabt_pkg::ADR_DATA && status_armed_q
        && transmit_empty_flag_q && port_enable;
    // move waiting word once enabled and idle
    assign load = state_q == uabt_pkg::TX_IDLE && !transmit_empty_flag_q && transmit_enable;

    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            serial_data_buffer_q <= 8'h00;
        end else if (data_wr_ok) begin
            serial_data_buffer_q <= I_WB_DAT[7:0];
        end
    end

    // empty on disable; set again at load
    always_ff @(posedge I_MCLK) begin
        if (I_RST || !port_enable) begin
            transmit_empty_flag_q <= 1'b1;
        end else if (load) begin
            transmit_empty_flag_q <= 1'b1;
        end else if (data_wr_ok) begin
            transmit_empty_flag_q <= 1'b0;
        end
    end

    // frame end sets idle, and wins over a clearing write
    always_ff @(posedge I_MCLK) begin
        if (I_RST || !port_enable) begin
            transmit_idle_flag_q <= 1'b1;
        end else if (state_q == uabt_pkg::TX_DONE) begin
            transmit_idle_flag_q <= 1'b1;
        end else if (data_wr_ok) begin
            transmit_idle_flag_q <= 1'b0;
        end
    end

    // even parity is the xor; odd inverts it
    assign par8 = (^serial_data_buffer_q[6:0]) ^ serial_control_one_q[uabt_pkg::C1_PAR_ODD];
    assign par9 = (^serial_data_buffer_q) ^ serial_control_one_q[uabt_pkg::C1_PAR_ODD];

    // top data position carries ninth bit or parity
    always_comb begin
        word = {1'b1, serial_data_buffer_q};
        if (serial_control_one_q[uabt_pkg::C1_NINE]) begin
            word[8] = serial_control_one_q[uabt_pkg::C1_PAR_EN] ? par9
                : serial_control_one_q[uabt_pkg::C1_NINTH_BIT];
        end else if (serial_control_one_q[uabt_pkg::C1_PAR_EN]) begin
            word[7] = par8;
        end
    end

    // start, data, then one or two two_stop_select, transmit only
    assign frame_d = {2'b11, word, 1'b0};
    assign len_d = uabt_pkg::LEN_BASE
        + (serial_control_one_q[uabt_pkg::C1_NINE] ? uabt_pkg::DATA_NINE : uabt_pkg::DATA_EIGHT)
        + (serial_control_one_q[uabt_pkg::C1_TWO_STOP] ? uabt_pkg::STOP_TWO : uabt_pkg::STOP_ONE);

    // Transmit sequencer; first tick aligns the start bit to a full period
    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            state_q <= uabt_pkg::TX_IDLE;
            transmit_shift_reg_q <= '1;
            frame_len_q <= 4'h0;
            bit_cnt_q <= 4'h0;
        end else if (!transmit_enable) begin
            // abort on port or transmit disable
            state_q <= uabt_pkg::TX_IDLE;
            transmit_shift_reg_q <= '1;
            bit_cnt_q <= 4'h0;
        end else begin
            unique case (state_q)
                uabt_pkg::TX_IDLE: begin
                    if (load) begin
                        state_q <= uabt_pkg::TX_ARM;
                        transmit_shift_reg_q <= frame_d;
                        frame_len_q <= len_d;
                        bit_cnt_q <= 4'h0;
                    end
                end
                uabt_pkg::TX_ARM: begin
                    if (tick) begin
                        state_q <= uabt_pkg::TX_SEND;
                    end
                end
                uabt_pkg::TX_SEND: begin
                    if (tick) begin
                        // shift right so the low bit leaves first
                        transmit_shift_reg_q <= {1'b1, transmit_shift_reg_q[uabt_pkg::FRAME_W-1:1]};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                        // reload only after the last stop bit
                        if (bit_cnt_q == frame_len_q - 4'h1) begin
                            state_q <= uabt_pkg::TX_DONE;
                        end
                    end
                end
                uabt_pkg::TX_DONE: begin
                    state_q <= uabt_pkg::TX_IDLE;
                end
            endcase
        end
    end

    // line rests high outside a frame; one cycle behind the sequencer
    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            O_TX <= 1'b1;
        end else begin
            O_TX <= (state_q == uabt_pkg::TX_SEND && transmit_enable)
                ? transmit_shift_reg_q[0] : 1'b1;
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            O_TX_OE <= 1'b0;
            O_RX_EN <= 1'b0;
        end else begin
            O_TX_OE <= transmit_enable;
            O_RX_EN <= port_enable && serial_control_two_q[uabt_pkg::C2_RX_EN];
        end
    end

    // transmit request from empty and idle flags
    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            O_TX_IRQ <= 1'b0;
        end else begin
            O_TX_IRQ <= port_enable
                && ((transmit_empty_flag_q && serial_control_two_q[uabt_pkg::C2_EMPTY_IE])
                || (transmit_idle_flag_q && serial_control_two_q[uabt_pkg::C2_IDLE_IE]));
        end
    end

    // Checking aid: word captured at load
    logic [8:0] loaded_q;
    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            loaded_q <= 9'h000;
        end else if (load) begin
            loaded_q <= word;
        end
    end

    default clocking cb @(posedge I_MCLK);
    endclocking
    default disable iff (I_RST);

    AST_IDLE_HIGH: assert property (
        state_q == uabt_pkg::TX_IDLE |=> O_TX)
        else $error("Line not high while idle");
    AST_DISABLE_FLAGS: assert property (
        !port_enable |=> transmit_empty_flag_q && transmit_idle_flag_q
            && !serial_control_two_q[uabt_pkg::C2_TX_EN] && !O_TX_OE)
        else $error("Disabled port flags wrong");
    AST_ABORT: assert property (
        $fell(port_enable) |=> state_q == uabt_pkg::TX_IDLE ##1 O_TX)
        else $error("Port disable did not abort frame");
    AST_TRANSMIT_ENABLE_STOP: assert property (
        port_enable && state_q == uabt_pkg::TX_SEND && !transmit_enable
        |=> state_q == uabt_pkg::TX_IDLE && O_TX)
        else $error("Transmit disable did not stop frame");
    AST_WRITE_IGNORED: assert property (
        wb_wr && I_WB_ADR == uabt_pkg::ADR_DATA && !transmit_empty_flag_q
        |=> $stable(serial_data_buffer_q))
        else $error("Buffer changed while not empty");
    AST_START_LOW: assert property (
        state_q == uabt_pkg::TX_ARM && tick && transmit_enable ##1 transmit_enable |=> !O_TX)
        else $error("Start bit not low");
    AST_LSB_FIRST: assert property (
        state_q == uabt_pkg::TX_SEND && bit_cnt_q == 4'h1
        |-> transmit_shift_reg_q[0] == loaded_q[0])
        else $error("First data bit not the low bit");
    AST_EMPTY_SET: assert property (
        load |=> transmit_empty_flag_q && state_q == uabt_pkg::TX_ARM)
        else $error("Empty flag not set at load");
    AST_IDLE_SET: assert property (
        state_q == uabt_pkg::TX_DONE |=> transmit_idle_flag_q)
        else $error("Idle flag not set at frame end");
    AST_PARITY: assert property (
        load && serial_control_one_q[uabt_pkg::C1_PAR_EN]
        |-> ((serial_control_one_q[uabt_pkg::C1_NINE] ? ^word : ^word[7:0])
            == serial_control_one_q[uabt_pkg::C1_PAR_ODD]))
        else $error("Parity sense wrong");
    AST_FRAME_LEN: assert property (
        state_q == uabt_pkg::TX_DONE |-> bit_cnt_q == frame_len_q)
        else $error("Frame bit count wrong");
    AST_CLEAR_SEQ: assert property (
        data_wr_ok |=> !transmit_empty_flag_q)
        else $error("Empty flag not cleared by sequence");
    AST_LATE_ENABLE: assert property (
        $rose(transmit_enable) && !transmit_empty_flag_q && state_q == uabt_pkg::TX_IDLE
        |=> state_q == uabt_pkg::TX_ARM)
        else $error("Waiting word not started on enable");

    COV_FRAME: cover property (state_q == uabt_pkg::TX_SEND ##[1:300] state_q == uabt_pkg::TX_DONE);
    COV_BACK_TO_BACK: cover property (state_q == uabt_pkg::TX_DONE ##1 load);
    COV_NINE_PARITY: cover property (load && serial_control_one_q[uabt_pkg::C1_NINE]
        && serial_control_one_q[uabt_pkg::C1_PAR_EN]);
    COV_ABORT: cover property (state_q == uabt_pkg::TX_SEND ##1 !port_enable);
endmodule
`default_nettype wire

//--- sim/uabt_line_model.sv
`default_nettype none
module uabt_line_model (
    input wire logic i_clk,
    input wire logic i_line,
    input wire logic i_oe,
    input var int i_period,
    input var int i_nbits,
    output logic [11:0] o_bits,
    output int o_frames,
    output int o_low_len
);
    timeunit 1ns;
    timeprecision 1ns;

    int run_q = 0;

    // Length of the latest low run on the line, in clocks
    always @(posedge i_clk) begin
        if (i_line === 1'b0) begin
            run_q <= run_q + 1;
        end else begin
            if (run_q != 0) begin
                o_low_len <= run_q;
            end
            run_q <= 0;
        end
    end

    // Mid-bit sampling tolerates a start edge up to half a period late
    initial begin
        o_bits = 12'h000;
        o_frames = 0;
        forever begin
            @(posedge i_clk);
            if (i_oe === 1'b1 && i_line === 1'b0) begin
                o_bits = 12'h000;
                repeat (i_period / 2) @(posedge i_clk);
                for (int i = 0; i < i_nbits; i++) begin
                    repeat (i_period) @(posedge i_clk);
                    o_bits[i] = i_line;
                end
                o_frames = o_frames + 1;
            end
        end
    end
endmodule
`default_nettype wire

//--- sim/tb_top.sv
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [3:0] sel = 4'h0;
    logic [31:0] rdat;
    logic ack, tx, tx_oe, rx_en, irq;
    logic [11:0] bits;
    logic [7:0] rd;
    int frames, low_len;
    int period = 16;
    int nbits = 9;
    int fail_count = 0;
    int compares = 0;
    int cycles = 0;

    uabt_top DUT (.I_MCLK(mclk), .I_RST(rst), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
        .I_WB_ADR(adr), .I_WB_DAT(wdat), .I_WB_SEL(sel), .O_WB_DAT(rdat), .O_WB_ACK(ack),
        .O_TX(tx), .O_TX_OE(tx_oe), .O_RX_EN(rx_en), .O_TX_IRQ(irq));

    uabt_line_model peer (.i_clk(mclk), .i_line(tx), .i_oe(tx_oe), .i_period(period),
        .i_nbits(nbits), .o_bits(bits), .o_frames(frames), .o_low_len(low_len));

    // 100 MHz clock
    always #5 mclk = ~mclk;

    // Cuts a hang short; whole run needs well under this
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            fail_count = fail_count + 1;
            final_report();
        end
    end

    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input logic [11:0] got, input logic [11:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t ns: %s", $time, what);
        end
    endtask

    // Classic single cycle, held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        sel <= 4'h1;
        do begin
            @(posedge mclk);
            n++;
        end while (ack !== 1'b1);
        rd = rdat[7:0];
        check(12'(n), 12'h2, "bus ack latency");
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic send(input logic [7:0] d);
        wb(1'b0, uabt_pkg::ADR_STATUS, 8'h00);
        wb(1'b1, uabt_pkg::ADR_DATA, d);
    endtask

    task automatic wait_frames(input int k);
        int n;
        n = 0;
        while (frames < k && n < 5000) begin
            @(posedge mclk);
            n++;
        end
        if (n == 5000) check(12'h0, 12'h1, "frame missing");
    endtask

    task automatic setup(input logic [7:0] c1, input logic [7:0] c2, input logic [7:0] bd);
        wb(1'b1, uabt_pkg::ADR_CTRL_ONE, c1);
        wb(1'b1, uabt_pkg::ADR_CTRL_TWO, c2);
        wb(1'b1, uabt_pkg::ADR_BAUD, bd);
    endtask

    task automatic t_reset();
        wb(1'b0, uabt_pkg::ADR_STATUS, 8'h00);
        check(rd, 8'he0, "status after reset");
        wb(1'b0, uabt_pkg::ADR_CTRL_ONE, 8'h00);
        check(rd, 8'h00, "format after reset");
        wb(1'b0, 8'h14, 8'h00);
        check(rd, 8'h00, "unmapped read");
        check({tx, tx_oe}, 2'b10, "idle line after reset");
    endtask

    task automatic t_8n1();
        int base;
        setup(8'h80, 8'ha0, 8'h00);
        base = frames;
        send(8'ha5);
        send(8'h3c);
        send(8'h77);
        wait_frames(base + 1);
        check(bits, 12'h1a5, "first frame");
        check(low_len, period, "fast bit period");
        wait_frames(base + 2);
        check(bits, 12'h13c, "queued frame");
    endtask

    task automatic t_parity();
        int base;
        for (int odd = 0; odd < 2; odd++) begin
            wb(1'b1, uabt_pkg::ADR_CTRL_ONE, 8'ha0 | 8'(odd << 4));
            base = frames;
            send(8'hb5);
            wait_frames(base + 1);
            check(bits, {4'h1, odd[0], 7'h35}, "parity frame");
        end
    endtask

    task automatic t_nine();
        int base;
        wb(1'b1, uabt_pkg::ADR_CTRL_ONE, 8'hc1);
        nbits = 10;
        base = frames;
        send(8'h3c);
        wait_frames(base + 1);
        check(bits, 12'h33c, "nine-bit frame");
        wb(1'b1, uabt_pkg::ADR_CTRL_ONE, 8'he1);
        base = frames;
        send(8'h3c);
        wait_frames(base + 1);
        check(bits, 12'h23c, "nine-bit parity frame");
    endtask

    task automatic t_two_stop();
        int base;
        setup(8'h88, 8'h80, 8'h01);
        period = 128;
        base = frames;
        send(8'h96);
        wait_frames(base + 1);
        check(bits, 12'h396, "two stop frame");
        check(low_len, 2 * period, "slow bit period");
    endtask

    task automatic t_ignore();
        int base;
        setup(8'h80, 8'ha0, 8'h00);
        period = 16;
        nbits = 9;
        base = frames;
        wb(1'b1, uabt_pkg::ADR_DATA, 8'h55);
        repeat (300) @(posedge mclk);
        check(12'(frames - base), 12'h0, "unarmed write sent");
        wb(1'b0, uabt_pkg::ADR_STATUS, 8'h00);
        check(rd, 8'he0, "idle and empty after frames");
    endtask

    task automatic t_irq();
        wb(1'b1, uabt_pkg::ADR_CTRL_TWO, 8'ha1);
        repeat (3) @(posedge mclk);
        check(irq, 1'b1, "empty request");
        wb(1'b1, uabt_pkg::ADR_CTRL_TWO, 8'ha0);
        repeat (3) @(posedge mclk);
        check(irq, 1'b0, "request masked");
        wb(1'b1, uabt_pkg::ADR_CTRL_TWO, 8'ha2);
        repeat (3) @(posedge mclk);
        check(irq, 1'b1, "idle request");
    endtask

    task automatic t_transmit_enable_off();
        int base;
        setup(8'h80, 8'ha0, 8'h00);
        send(8'h00);
        repeat (60) @(posedge mclk);
        wb(1'b1, uabt_pkg::ADR_CTRL_TWO, 8'h20);
        repeat (3) @(posedge mclk);
        check({tx, tx_oe}, 2'b10, "abort on transmit off");
        // Let the peer finish its broken capture
        repeat (250) @(posedge mclk);
        base = frames;
        send(8'h81);
        repeat (100) @(posedge mclk);
        check(12'(frames - base), 12'h0, "sent while transmit off");
        wb(1'b1, uabt_pkg::ADR_CTRL_TWO, 8'ha0);
        wait_frames(base + 1);
        check(bits, 12'h181, "word loaded before enable");
    endtask

    task automatic t_disable();
        int base;
        setup(8'h80, 8'he0, 8'h01);
        check({tx_oe, rx_en}, 2'b11, "pins owned when enabled");
        period = 32;
        send(8'h00);
        repeat (100) @(posedge mclk);
        wb(1'b1, uabt_pkg::ADR_CTRL_ONE, 8'h00);
        repeat (3) @(posedge mclk);
        check({tx, tx_oe, rx_en}, 3'b100, "pins released");
        repeat (400) @(posedge mclk);
        wb(1'b0, uabt_pkg::ADR_STATUS, 8'h00);
        check(rd, 8'he0, "status after disable");
        wb(1'b0, uabt_pkg::ADR_CTRL_TWO, 8'h00);
        check(rd, 8'h20, "control kept, enables cleared");
        wb(1'b0, uabt_pkg::ADR_BAUD, 8'h00);
        check(rd, 8'h01, "divisor kept");
        wb(1'b1, uabt_pkg::ADR_CTRL_ONE, 8'h80);
        wb(1'b1, uabt_pkg::ADR_CTRL_TWO, 8'ha0);
        base = frames;
        send(8'h5a);
        wait_frames(base + 1);
        check(bits, 12'h15a, "frame after re-enable");
    endtask

    // Main sequence
    initial begin
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        t_reset();
        t_8n1();
        t_parity();
        t_nine();
        t_two_stop();
        t_ignore();
        t_irq();
        t_transmit_enable_off();
        t_disable();
        final_report();
    end
endmodule
`default_nettype wire
